// *** cfi_consts.svh ***
`ifndef CFI_CONSTS_SVH
`define CFI_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CFI_OFS_CTRL      8'h00
`define CFI_OFS_STATUS    8'h1C
`define CFI_OFS_ENABLE    8'h20
`define CFI_OFS_CLEAR     8'h24

// ------------------------------------------------------------
// Widths and field layout
// ------------------------------------------------------------
`define CFI_ADDR_W        8
`define CFI_DATA_W        32
`define CFI_FLAG_W        18
`define CFI_CEN_BIT       0
`define CFI_WM_BIT        12

// Implemented flag positions: 17..8, 6, 4..0 (7 and 5 reserved)
`define CFI_FLAG_MASK     18'h3_FF5F
// Flags also wiped when the core enable is written to zero
`define CFI_CEN_CLR_MASK  18'h0_0F5F

// ------------------------------------------------------------
// Reset values and bus responses
// ------------------------------------------------------------
`define CFI_ENABLE_RST    18'h0_0000
`define CFI_STATUS_RST    18'h0_0000
`define CFI_CEN_RST       1'h0
`define CFI_RESP_OKAY     2'h0
`define CFI_RESP_SLVERR   2'h2

`endif

// *** cfi_pkg.sv ***
package cfi_pkg;
   // Flag vector, one bit per event position
   typedef logic [17:0] cfi_flags_t;

   // Register selected by an address decode
   typedef enum logic [4:0] {
      CFI_SEL_CTRL   = 5'b0_0001,
      CFI_SEL_STATUS = 5'b0_0010,
      CFI_SEL_ENABLE = 5'b0_0100,
      CFI_SEL_CLEAR  = 5'b0_1000,
      CFI_SEL_NONE   = 5'b1_0000
   } cfi_sel_t;

   // Read channel states
   typedef enum logic [1:0] {
      CFI_RD_IDLE = 2'b01,
      CFI_RD_RESP = 2'b10
   } cfi_rd_state_t;
endpackage

// *** cfi_flag_if.sv ***
`timescale 1ns/1ns
// Carries the flag state between the register front end and its helpers
interface cfi_flag_if;
   import cfi_pkg::*;
   cfi_flags_t status;
   cfi_flags_t enable;
   cfi_flags_t clr;
   cfi_flags_t events;
   logic       cen_clr;
   logic       wm_above;
   logic       irq;

   modport regs (output enable, output clr, output events, output cen_clr,
                 output wm_above, input status, input irq);
   modport bank (input clr, input events, input cen_clr, input wm_above,
                 output status);
   modport gate (input status, input enable, output irq);
endinterface

// *** cfi_status_bank.sv ***
`timescale 1ns/1ns
`include "cfi_consts.svh"
module cfi_status_bank (
   input  wire logic    aclk,
   input  wire logic    aresetn,
   cfi_flag_if.bank     fl
);
   import cfi_pkg::*;

   cfi_flags_t status_r;
   cfi_flags_t status_nxt;
   cfi_flags_t set_v;
   cfi_flags_t wipe_v;

   // ------------------------------------------------------------
   // Sticky flags
   // ------------------------------------------------------------
   // Set terms are OR-ed last so a same-cycle event beats any clear
   always_comb begin
      set_v = fl.events;
      set_v[`CFI_WM_BIT] = fl.events[`CFI_WM_BIT] | fl.wm_above;
      wipe_v = fl.clr;
      if (fl.cen_clr) begin
         wipe_v = wipe_v | `CFI_CEN_CLR_MASK;
      end
      status_nxt = ((status_r & ~wipe_v) | set_v) & `CFI_FLAG_MASK;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= `CFI_STATUS_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   assign fl.status = status_r;
endmodule

// *** cfi_irq_gate.sv ***
`timescale 1ns/1ns
`include "cfi_consts.svh"
module cfi_irq_gate (
   input  wire logic    aclk,
   input  wire logic    aresetn,
   cfi_flag_if.gate     fl
);
   import cfi_pkg::*;

   logic irq_r;

   // ------------------------------------------------------------
   // Request output
   // ------------------------------------------------------------
   // Registered so the pin is glitch free; costs one cycle of latency
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(fl.status & fl.enable & `CFI_FLAG_MASK);
      end
   end

   assign fl.irq = irq_r;
endmodule

// *** cfi_irq_top.sv ***
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`include "cfi_consts.svh"
module cfi_irq_top (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address
   input  wire logic [`CFI_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic [2:0]                 s_axi_awprot,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [`CFI_DATA_W-1:0]     s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [`CFI_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic [2:0]                 s_axi_arprot,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   // AXI4-Lite read data
   output logic [`CFI_DATA_W-1:0]          s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Core side
   input  wire cfi_pkg::cfi_flags_t        event_set,
   input  wire logic                       fifo_above_watermark,
   output logic                            core_enable,
   output logic                            irq
);
   import cfi_pkg::*;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Word decode; low two address bits are ignored as the bus is word wide
   function automatic cfi_sel_t cfi_decode(input logic [`CFI_ADDR_W-1:0] addr);
      logic [`CFI_ADDR_W-1:0] word;
      word = {addr[`CFI_ADDR_W-1:2], 2'b00};
      if (word == `CFI_OFS_CTRL) begin
         cfi_decode = CFI_SEL_CTRL;
      end else if (word == `CFI_OFS_STATUS) begin
         cfi_decode = CFI_SEL_STATUS;
      end else if (word == `CFI_OFS_ENABLE) begin
         cfi_decode = CFI_SEL_ENABLE;
      end else if (word == `CFI_OFS_CLEAR) begin
         cfi_decode = CFI_SEL_CLEAR;
      end else begin
         cfi_decode = CFI_SEL_NONE;
      end
   endfunction

   // Byte-lane merge of new write data over an old value
   function automatic logic [31:0] cfi_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      cfi_merge = res;
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   cfi_flag_if fl ();

   logic                   awready_r;
   logic                   wready_r;
   logic                   bvalid_r;
   logic [1:0]             bresp_r;
   logic                   arready_r;
   logic                   rvalid_r;
   logic [1:0]             rresp_r;
   logic [31:0]            rdata_r;
   logic                   aw_hold_r;
   logic                   w_hold_r;
   logic [`CFI_ADDR_W-1:0] waddr_r;
   logic [31:0]            wdata_r;
   logic [3:0]             wstrb_r;
   cfi_flags_t             enable_r;
   cfi_flags_t             clr_r;
   logic                   cen_r;
   logic                   cen_clr_r;
   cfi_rd_state_t          rd_state_r;
   logic                   wr_commit;
   cfi_sel_t               wsel;
   cfi_sel_t               rsel;
   logic [31:0]            wmerged_ctrl;
   logic [31:0]            wmerged_en;
   logic [31:0]            wmasked_clr;
   logic [31:0]            rdata_nxt;

   // ------------------------------------------------------------
   // Helper instances
   // ------------------------------------------------------------
   cfi_status_bank u_bank (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fl      (fl.bank)
   );

   cfi_irq_gate u_gate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fl      (fl.gate)
   );

   // Register and core-side connections into the flag carrier
   assign fl.enable   = enable_r;
   assign fl.clr      = clr_r;
   assign fl.cen_clr  = cen_clr_r;
   assign fl.events   = event_set;
   assign fl.wm_above = fifo_above_watermark;

   // ------------------------------------------------------------
   // Write channel
   // ------------------------------------------------------------
   // Address and data are caught separately, in either order
   assign wr_commit = aw_hold_r && w_hold_r && !bvalid_r;
   assign wsel      = cfi_decode(waddr_r);

   // Address capture; ready stays low until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b1;
         waddr_r   <= '0;
      end else if (s_axi_awvalid && awready_r) begin
         aw_hold_r <= 1'b1;
         awready_r <= 1'b0;
         waddr_r   <= s_axi_awaddr;
      end else if (wr_commit) begin
         aw_hold_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
         awready_r <= 1'b1;
      end
   end

   // Data capture, mirror of the address side
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b1;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (s_axi_wvalid && wready_r) begin
         w_hold_r <= 1'b1;
         wready_r <= 1'b0;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (wr_commit) begin
         w_hold_r <= 1'b0;
      end else if (bvalid_r && s_axi_bready) begin
         wready_r <= 1'b1;
      end
   end

   // Response; unmapped or read-only targets answer with a slave error
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `CFI_RESP_OKAY;
      end else if (wr_commit) begin
         bvalid_r <= 1'b1;
         if (wsel == CFI_SEL_NONE || wsel == CFI_SEL_STATUS) begin
            bresp_r <= `CFI_RESP_SLVERR;
         end else begin
            bresp_r <= `CFI_RESP_OKAY;
         end
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   always_comb begin
      wmerged_ctrl = cfi_merge({31'h0, cen_r}, wdata_r, wstrb_r);
      wmerged_en   = cfi_merge({14'h0, enable_r}, wdata_r, wstrb_r);
      wmasked_clr  = cfi_merge(32'h0000_0000, wdata_r, wstrb_r);
   end

   // Enable bits; reserved positions never store a one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r <= `CFI_ENABLE_RST;
      end else if (wr_commit && wsel == CFI_SEL_ENABLE) begin
         enable_r <= wmerged_en[`CFI_FLAG_W-1:0] & `CFI_FLAG_MASK;
      end
   end

   // Clear pulses live one cycle; nothing is stored behind them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clr_r <= '0;
      end else if (wr_commit && wsel == CFI_SEL_CLEAR) begin
         clr_r <= wmasked_clr[`CFI_FLAG_W-1:0] & `CFI_FLAG_MASK;
      end else begin
         clr_r <= '0;
      end
   end

   // Core enable; any write of zero wipes the flags tied to it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cen_r     <= `CFI_CEN_RST;
         cen_clr_r <= 1'b0;
      end else if (wr_commit && wsel == CFI_SEL_CTRL && wstrb_r[0]) begin
         cen_r     <= wmerged_ctrl[`CFI_CEN_BIT];
         cen_clr_r <= !wmerged_ctrl[`CFI_CEN_BIT];
      end else begin
         cen_clr_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   assign rsel = cfi_decode(s_axi_araddr);

   // Read mux; unused and reserved bits return zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rsel == CFI_SEL_CTRL) begin
         rdata_nxt[`CFI_CEN_BIT] = cen_r;
      end else if (rsel == CFI_SEL_STATUS) begin
         rdata_nxt[`CFI_FLAG_W-1:0] = fl.status;
      end else if (rsel == CFI_SEL_ENABLE) begin
         rdata_nxt[`CFI_FLAG_W-1:0] = enable_r & `CFI_FLAG_MASK;
      end else begin
         rdata_nxt = 32'h0000_0000;
      end
   end

   // One read in flight; address accepted only when idle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_r <= CFI_RD_IDLE;
         arready_r  <= 1'b1;
         rvalid_r   <= 1'b0;
         rdata_r    <= 32'h0000_0000;
         rresp_r    <= `CFI_RESP_OKAY;
      end else begin
         case (rd_state_r)
            CFI_RD_IDLE: begin
               if (s_axi_arvalid && arready_r) begin
                  rd_state_r <= CFI_RD_RESP;
                  arready_r  <= 1'b0;
                  rvalid_r   <= 1'b1;
                  rdata_r    <= rdata_nxt;
                  if (rsel == CFI_SEL_NONE) begin
                     rresp_r <= `CFI_RESP_SLVERR;
                  end else begin
                     rresp_r <= `CFI_RESP_OKAY;
                  end
               end
            end
            CFI_RD_RESP: begin
               if (s_axi_rready) begin
                  rd_state_r <= CFI_RD_IDLE;
                  arready_r  <= 1'b1;
                  rvalid_r   <= 1'b0;
               end
            end
            default: begin
               rd_state_r <= CFI_RD_IDLE;
               arready_r  <= 1'b1;
               rvalid_r   <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flops
   // ------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign core_enable   = cen_r;
   assign irq           = fl.irq;
endmodule

// *** cfi_irq_sva.sv ***
`timescale 1ns/1ns
`include "cfi_consts.svh"
// ------------------------------------------------------------
// Port checker for the interrupt enable and clear block
// ------------------------------------------------------------
module cfi_irq_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        core_enable,
   input wire logic        irq
);
   // One clock domain, so clock and reset are given once
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Both write channels taken at one edge, as the host offers them together
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence

   property p_wr_answer;
      s_wr_take |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_rd_answer;
      s_rd_take |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_clr_zero;
      s_rd_take ##0 (s_axi_araddr == `CFI_OFS_CLEAR) |=>
         s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `CFI_RESP_OKAY;
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clear reads nonzero");
   property p_en_rsvd;
      s_rd_take ##0 (s_axi_araddr == `CFI_OFS_ENABLE) |=> (s_axi_rdata & 32'hFFFC_00A0) == 0;
   endproperty
   a_en_rsvd: assert property (p_en_rsvd) else $error("reserved enable bit set");
   property p_stat_wr;
      s_wr_take ##0 (s_axi_awaddr == `CFI_OFS_STATUS) |-> ##2 s_axi_bresp == `CFI_RESP_SLVERR;
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status write accepted");
   // Enable write of all zeros must silence the request line
   property p_irq_off;
      s_wr_take ##0 (s_axi_awaddr == `CFI_OFS_ENABLE && s_axi_wstrb == 4'hF
         && (s_axi_wdata[17:0] & `CFI_FLAG_MASK) == 18'h0_0000) |-> ##4 !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
   property p_cen;
      s_wr_take ##0 (s_axi_awaddr == `CFI_OFS_CTRL && s_axi_wstrb[0])
         |-> ##3 core_enable == $past(s_axi_wdata[0], 3);
   endproperty
   a_cen: assert property (p_cen) else $error("core enable not written");
   property p_irq_rst;
      $rose(aresetn) |-> !irq && !core_enable;
   endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("outputs not reset");
endmodule

bind cfi_irq_top cfi_irq_sva chk (.*);

// *** cfi_host_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Host side register bus master
// ------------------------------------------------------------
module cfi_host_model (
   input  wire logic        aclk,
   output logic [7:0]       s_axi_awaddr,
   output logic [2:0]       s_axi_awprot,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [7:0]       s_axi_araddr,
   output logic [2:0]       s_axi_arprot,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   // Idle bus; full word lanes always, since every register is one word
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
   end

   // Readies only move at rising edges, so the falling edge shows what the next edge sees
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic aw_ok, w_ok, b_ok;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(negedge aclk);
         aw_ok = s_axi_awready;
         w_ok  = s_axi_wready;
         b_ok  = s_axi_bvalid;
         resp  = s_axi_bresp;
         @(posedge aclk);
         if (aw_ok)
            s_axi_awvalid <= 1'b0;
         if (w_ok)
            s_axi_wvalid <= 1'b0;
      end while (!b_ok);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic ar_ok, r_ok;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(negedge aclk);
         ar_ok = s_axi_arready;
         r_ok  = s_axi_rvalid;
         d     = s_axi_rdata;
         resp  = s_axi_rresp;
         @(posedge aclk);
         if (ar_ok)
            s_axi_arvalid <= 1'b0;
      end while (!r_ok);
      s_axi_rready <= 1'b0;
   endtask
endmodule

// *** test_can_fd_irq_enable_clear.sv ***
`timescale 1ns/1ns
`include "cfi_consts.svh"
// ------------------------------------------------------------
// Self-checking bench for the interrupt enable and clear block
// ------------------------------------------------------------
module test_can_fd_irq_enable_clear;
   import cfi_pkg::*;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t: got %h want %h", $time, g, e); end end
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] b; logic [31:0] q; logic [1:0] r;} cfi_row_t;
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, fifo_above_watermark, core_enable, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [3:0]  s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [1:0]  s_axi_bresp, s_axi_rresp, b_r, r_r;
   cfi_flags_t  event_set;
   cfi_flags_t  flag_m = `CFI_FLAG_MASK;
   int          err_total = 0, comparisons = 0, cyc = 0, i;
   // Plain accesses: address, data, write answer, read-back, read answer
   cfi_row_t    rows [6] = '{
      '{`CFI_OFS_ENABLE, 32'hFFFF_FFFF, 2'h0, 32'h0003_FF5F, 2'h0},
      '{`CFI_OFS_ENABLE, 32'hFFFC_00A0, 2'h0, 32'h0000_0000, 2'h0},
      '{`CFI_OFS_CLEAR,  32'hFFFF_FFFF, 2'h0, 32'h0000_0000, 2'h0},
      '{`CFI_OFS_STATUS, 32'hFFFF_FFFF, 2'h2, 32'h0000_0000, 2'h0},
      '{8'h40,           32'h1234_5678, 2'h2, 32'h0000_0000, 2'h2},
      '{`CFI_OFS_CTRL,   32'h0000_0001, 2'h0, 32'h0000_0001, 2'h0}};

   cfi_irq_top uut (.*);
   cfi_host_model host (.*);

   // Clock and hang guard; a full run needs well under 3000 cycles
   always #20 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Flag to irq takes two edges; leave margin, then sample away from the edge
   task automatic settle;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic pulse(input cfi_flags_t ev);
      @(posedge aclk);
      event_set <= ev;
      @(posedge aclk);
      event_set <= '0;
      settle();
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host.rd(a, rd_d, r_r);
      `CHK(rd_d, exp)
   endtask

   task automatic rst_chk;
      // The edge below samples reset low only on the first call, so four low edges then and three on later calls
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`CFI_OFS_ENABLE, 32'h0000_0000);
      rd_chk(`CFI_OFS_STATUS, 32'h0000_0000);
      @(negedge aclk);
      `CHK({irq, core_enable}, 2'b00)
      $display("reset test done");
   endtask

   initial begin
      aresetn = 1'b0;
      event_set = '0;
      fifo_above_watermark = 1'b0;
      rst_chk();
      foreach (rows[k]) begin
         host.wr(rows[k].a, rows[k].d, b_r);
         `CHK(b_r, rows[k].b)
         host.rd(rows[k].a, rd_d, r_r);
         `CHK(rd_d, rows[k].q)
         `CHK(r_r, rows[k].r)
      end
      $display("row test done");
      // Each position: masked event, then unmasked, then cleared
      for (i = 0; i < 18; i++) begin
         host.wr(`CFI_OFS_ENABLE, ~(32'h1 << i), b_r);
         pulse(18'h1 << i);
         `CHK(irq, 1'b0)
         rd_chk(`CFI_OFS_STATUS, {14'h0, flag_m & (18'h1 << i)});
         host.wr(`CFI_OFS_ENABLE, 32'h0003_FFFF, b_r);
         settle();
         `CHK(irq, flag_m[i])
         host.wr(`CFI_OFS_CLEAR, 32'h1 << i, b_r);
         rd_chk(`CFI_OFS_STATUS, 32'h0000_0000);
         settle();
         `CHK(irq, 1'b0)
      end
      $display("bit test done");
      pulse(18'h3_FFFF);
      host.wr(`CFI_OFS_CLEAR, 32'h0000_0000, b_r);
      rd_chk(`CFI_OFS_STATUS, {14'h0, flag_m});
      host.wr(`CFI_OFS_CTRL, 32'h0000_0000, b_r);
      rd_chk(`CFI_OFS_STATUS, {14'h0, (flag_m & ~`CFI_CEN_CLR_MASK)});
      `CHK(core_enable, 1'b0)
      // Event held across the clearing edge must survive it
      @(posedge aclk);
      event_set <= 18'h0_0001;
      host.wr(`CFI_OFS_CLEAR, 32'h0003_FFFF, b_r);
      event_set <= '0;
      rd_chk(`CFI_OFS_STATUS, 32'h0000_0001);
      fifo_above_watermark <= 1'b1;
      settle();
      host.wr(`CFI_OFS_CLEAR, 32'h0000_1001, b_r);
      rd_chk(`CFI_OFS_STATUS, 32'h0000_1000);
      fifo_above_watermark <= 1'b0;
      host.wr(`CFI_OFS_CLEAR, 32'h0000_1000, b_r);
      rd_chk(`CFI_OFS_STATUS, 32'h0000_0000);
      $display("edge case test done");
      // Arm every flag and the core enable so the reset has something to undo
      host.wr(`CFI_OFS_CTRL, 32'h0000_0001, b_r);
      pulse(18'h3_FFFF);
      `CHK({irq, core_enable}, 2'b11)
      rst_chk();
      wrap_up();
   end
endmodule
